// ==== hdl/serial_tx_rx_datapath.sv ====
`timescale 1ns/100ps
`include "serial_cfg.svh"
module serial_tx_rx_datapath #(
  parameter int BAUD_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  input wire logic xck_in,
  output logic serial_in_claimed,
  input wire logic irq_ack_tx_complete,
  output logic irq_data_empty,
  output logic irq_tx_complete
);
  initial begin
    if (BAUD_W < 1 || BAUD_W > 16) $error("BAUD_W out of range");
  end

  serial_pkg::ctrl_t ctrl_q;
  logic [BAUD_W-1:0] baud_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, rd_fire, data_wr, data_rd;
  logic [7:0] rd_addr;

  // write address and data latched independently, in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;
  assign data_wr = wr_fire && awaddr_q == `SER_ADDR_DATA && wstrb_q[0];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr[7:0];
  assign data_rd = rd_fire && rd_addr == `SER_ADDR_DATA;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > `SER_ADDR_DATA || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= '0;
      baud_q <= BAUD_W'(`SER_BAUD_RESET);
    end else if (wr_fire) begin
      if (awaddr_q == `SER_ADDR_CTRL) begin
        if (wstrb_q[0]) ctrl_q <= {wdata_q[`SER_CTRL_TX_ON], wdata_q[`SER_CTRL_RXEN], wdata_q[`SER_CTRL_UDRIE],
          wdata_q[`SER_CTRL_TXCIE], wdata_q[`SER_CTRL_SYNC], wdata_q[`SER_CTRL_U2X], wdata_q[`SER_CTRL_PEN],
          wdata_q[`SER_CTRL_PODD], wdata_q[`SER_CTRL_STOP2], wdata_q[`SER_CTRL_CSZ_LO+2:`SER_CTRL_CSZ_LO],
          wdata_q[`SER_CTRL_NINTH], wdata_q[`SER_CTRL_GIE]};
      end
      if (awaddr_q == `SER_ADDR_BAUD) baud_q <= wdata_q[BAUD_W-1:0];
    end
  end

  // pins from outside: two flops before any use
  logic rxd_m, rxd_s, xck_m, xck_s, xck_prev;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      xck_m <= 1'b0;
      xck_s <= 1'b0;
      xck_prev <= 1'b0;
    end else begin
      rxd_m <= serial_in_pin;
      rxd_s <= rxd_m;
      xck_m <= xck_in;
      xck_s <= xck_m;
      xck_prev <= xck_s;
    end
  end

  // oversample tick: 16 per bit, 8 with double speed
  logic [BAUD_W-1:0] div_q;
  logic os_tick, tx_tick, rx_sample, xck_rise, xck_fall;
  logic [3:0] os_q;
  logic [3:0] os_last;
  assign xck_rise = xck_s && !xck_prev;
  assign xck_fall = !xck_s && xck_prev;
  assign os_tick = div_q == '0;
  assign os_last = ctrl_q.double_speed ? 4'h7 : 4'hF;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= '0;
      os_q <= 4'h0;
    end else begin
      div_q <= os_tick ? baud_q : div_q - 1'b1;
      if (os_tick) os_q <= (os_q >= os_last) ? 4'h0 : os_q + 4'h1;
    end
  end
  assign tx_tick = ctrl_q.sync_mode ? xck_rise : (os_tick && os_q == os_last); // [R2] [R4]

  // transmitter
  serial_pkg::tx_state_t tx_st_q;
  logic [8:0] txbuf_q, txsh_q;
  logic txbuf_full_q, txd_q, tx_par_q, tx_stop2_q, txc_q, tx_active_q, tx_tail_q;
  logic [3:0] tx_cnt_q, nbits;
  logic [8:0] width_mask, wr_char;
  logic tx_load, tx_done;
  always_comb begin
    unique case (ctrl_q.character_size)
      3'h0: nbits = 4'd5;
      3'h1: nbits = 4'd6;
      3'h2: nbits = 4'd7;
      `SER_CSZ_NINE: nbits = 4'd9;
      default: nbits = 4'd8;
    endcase
    width_mask = 9'h1FF >> (4'd9 - nbits); // [R24]
  end
  assign wr_char = {ctrl_q.transmit_ninth_bit, wdata_q[7:0]} & width_mask; // [R5] [R6]
  assign tx_load = txbuf_full_q && (tx_st_q == serial_pkg::TX_IDLE) && tx_active_q; // [R3] [R15]
  assign tx_done = tx_tick && tx_tail_q && tx_st_q == serial_pkg::TX_IDLE && !txbuf_full_q; // [R11]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txbuf_q <= 9'h000;
      txbuf_full_q <= 1'b0;
    end else if (data_wr && ctrl_q.transmit_enable) begin
      txbuf_q <= wr_char; // [R3]
      txbuf_full_q <= 1'b1; // [R10]
    end else if (tx_load) begin
      txbuf_full_q <= 1'b0; // [R7]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_q <= serial_pkg::TX_IDLE;
      txsh_q <= 9'h000;
      txd_q <= 1'b1;
      tx_cnt_q <= 4'h0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else begin
      unique case (tx_st_q)
        serial_pkg::TX_IDLE: begin
          txd_q <= 1'b1; // [R21]
          if (tx_load) begin
            txsh_q <= txbuf_q;
            tx_par_q <= ^txbuf_q ^ ctrl_q.parity_odd_select; // [R22]
            tx_st_q <= serial_pkg::TX_START;
          end
        end
        serial_pkg::TX_START: if (tx_tick) begin
          txd_q <= 1'b0;
          tx_cnt_q <= 4'h0;
          tx_st_q <= serial_pkg::TX_DATA;
        end
        serial_pkg::TX_DATA: if (tx_tick) begin
          txd_q <= txsh_q[0]; // [R21]
          txsh_q <= txsh_q >> 1;
          tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tx_cnt_q + 4'h1 == nbits) tx_st_q <= ctrl_q.parity_enable ? serial_pkg::TX_PAR : serial_pkg::TX_STOP;
          tx_stop2_q <= ctrl_q.stop_bits_select;
        end
        serial_pkg::TX_PAR: if (tx_tick) begin
          txd_q <= tx_par_q; // [R14]
          tx_st_q <= serial_pkg::TX_STOP;
        end
        serial_pkg::TX_STOP: if (tx_tick) begin
          txd_q <= 1'b1;
          if (tx_stop2_q) tx_stop2_q <= 1'b0;
          else tx_st_q <= serial_pkg::TX_IDLE;
        end
        default: tx_st_q <= serial_pkg::TX_IDLE;
      endcase
    end
  end
  // last stop bit still on the line until the next tick; completion waits for it
  always_ff @(posedge clk_sys) begin
    if (rst) tx_tail_q <= 1'b0;
    else if (tx_tick) tx_tail_q <= tx_st_q == serial_pkg::TX_STOP && !tx_stop2_q; // [R11]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) tx_active_q <= 1'b0;
    else if (ctrl_q.transmit_enable) tx_active_q <= 1'b1; // [R1]
    else if (tx_st_q == serial_pkg::TX_IDLE && !txbuf_full_q && !tx_tail_q) tx_active_q <= 1'b0; // [R15]
  end
  assign serial_out_pin = tx_active_q ? txd_q : 1'b1;
  assign serial_out_oe = tx_active_q; // [R1]

  // transmit complete: set wins over clear
  logic txc_clr;
  assign txc_clr = irq_ack_tx_complete ||
    (wr_fire && awaddr_q == `SER_ADDR_STAT && wstrb_q[0] && wdata_q[`SER_STAT_TXC]); // [R12]
  always_ff @(posedge clk_sys) begin
    if (rst) txc_q <= 1'b0;
    else if (tx_done && !txbuf_full_q) txc_q <= 1'b1; // [R11]
    else if (txc_clr) txc_q <= 1'b0;
  end
  assign irq_data_empty = ctrl_q.data_empty_irq_enable && !txbuf_full_q && ctrl_q.global_irq_enable; // [R9]
  assign irq_tx_complete = ctrl_q.transmit_complete_irq_enable && txc_q && ctrl_q.global_irq_enable; // [R13]

  // receiver
  serial_pkg::rx_state_t rx_st_q;
  logic [8:0] rxsh_q;
  logic [3:0] rx_cnt_q, rx_os_q;
  logic rx_par_q, rx_tick, rx_mid;
  serial_pkg::rx_entry_t rxbuf_q [2];
  logic [1:0] rx_count_q;
  logic rd_ptr_q, wr_ptr_q, rx_push, dor_q;
  assign serial_in_claimed = ctrl_q.receive_enable; // [R16]
  assign rx_mid = ctrl_q.sync_mode ? xck_fall : (os_tick && rx_os_q == (os_last >> 1));
  assign rx_sample = rx_mid;
  assign rx_tick = ctrl_q.sync_mode ? xck_fall : (os_tick && rx_os_q == os_last);

  always_ff @(posedge clk_sys) begin
    if (rst || !ctrl_q.receive_enable) begin
      rx_st_q <= serial_pkg::RX_IDLE;
      rxsh_q <= 9'h000;
      rx_cnt_q <= 4'h0;
      rx_os_q <= 4'h0;
      rx_par_q <= 1'b0;
    end else begin
      if (os_tick || ctrl_q.sync_mode) rx_os_q <= (rx_os_q >= os_last) ? 4'h0 : rx_os_q + 4'h1;
      unique case (rx_st_q)
        serial_pkg::RX_IDLE: begin
          rx_os_q <= 4'h0;
          if (!rxd_s) rx_st_q <= serial_pkg::RX_START;
        end
        serial_pkg::RX_START: if (rx_sample) begin
          rx_cnt_q <= 4'h0;
          rx_par_q <= ctrl_q.parity_odd_select;
          rx_st_q <= rxd_s ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA; // [R17]
        end
        serial_pkg::RX_DATA: if (rx_sample) begin
          rxsh_q <= {rxd_s, rxsh_q[8:1]};
          rx_par_q <= rx_par_q ^ rxd_s;
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q + 4'h1 == nbits) rx_st_q <= ctrl_q.parity_enable ? serial_pkg::RX_PAR : serial_pkg::RX_STOP;
        end
        serial_pkg::RX_PAR: if (rx_sample) begin
          rx_par_q <= rx_par_q ^ rxd_s;
          rx_st_q <= serial_pkg::RX_STOP;
        end
        serial_pkg::RX_STOP: if (rx_sample) rx_st_q <= serial_pkg::RX_IDLE; // [R18]
        default: rx_st_q <= serial_pkg::RX_IDLE;
      endcase
    end
  end
  assign rx_push = rx_st_q == serial_pkg::RX_STOP && rx_sample && ctrl_q.receive_enable; // [R19]

  logic [8:0] rx_aligned;
  assign rx_aligned = (rxsh_q >> (4'd9 - nbits)) & width_mask; // [R20] [R24]
  logic rx_pop;
  assign rx_pop = data_rd && rx_count_q != 2'h0;
  always_ff @(posedge clk_sys) begin
    if (rst || !ctrl_q.receive_enable) begin
      rx_count_q <= 2'h0; // [R23]
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      dor_q <= 1'b0;
      rxbuf_q[0] <= '0;
      rxbuf_q[1] <= '0;
    end else begin
      if (rx_push && (rx_count_q != 2'h2 || rx_pop)) begin
        rxbuf_q[wr_ptr_q] <= '{data: rx_aligned, frame_err: !rxd_s, parity_err: ctrl_q.parity_enable && rx_par_q};
        wr_ptr_q <= !wr_ptr_q;
        dor_q <= 1'b0;
      end else if (rx_push) begin
        dor_q <= 1'b1;
      end
      if (rx_pop) rd_ptr_q <= !rd_ptr_q;
      rx_count_q <= rx_count_q + 2'((rx_push && (rx_count_q != 2'h2 || rx_pop)) ? 1 : 0) - 2'(rx_pop ? 1 : 0);
    end
  end

  // read channel
  serial_pkg::rx_entry_t head;
  assign head = rxbuf_q[rd_ptr_q];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (rd_addr)
        `SER_ADDR_CTRL: s_axi_rdata <= {18'h0, ctrl_q.global_irq_enable, ctrl_q.transmit_ninth_bit,
          ctrl_q.character_size, ctrl_q.stop_bits_select, ctrl_q.parity_odd_select, ctrl_q.parity_enable,
          ctrl_q.double_speed, ctrl_q.sync_mode, ctrl_q.transmit_complete_irq_enable,
          ctrl_q.data_empty_irq_enable, ctrl_q.receive_enable, ctrl_q.transmit_enable};
        `SER_ADDR_STAT: s_axi_rdata <= {25'h0, dor_q, head.data[8] && rx_count_q != 2'h0,
          head.parity_err && rx_count_q != 2'h0, head.frame_err && rx_count_q != 2'h0,
          rx_count_q != 2'h0, txc_q, !txbuf_full_q}; // [R7] [R23]
        `SER_ADDR_BAUD: s_axi_rdata <= 32'(baud_q);
        `SER_ADDR_DATA: s_axi_rdata <= {24'h0, head.data[7:0]}; // [R20]
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_empty_clear;
    @(posedge clk_sys) disable iff (rst) (data_wr && ctrl_q.transmit_enable) |=> txbuf_full_q;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("data write did not clear empty"); // [R10]
  property p_txc_set;
    @(posedge clk_sys) disable iff (rst) (tx_done && !txbuf_full_q) |=> txc_q;
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("transmit complete not set"); // [R11]
  property p_txc_irq;
    @(posedge clk_sys) disable iff (rst)
      (txc_q && ctrl_q.transmit_complete_irq_enable && ctrl_q.global_irq_enable) |-> irq_tx_complete;
  endproperty
  a_txc_irq: assert property (p_txc_irq) else $error("complete irq missing"); // [R13]
  property p_start_low;
    @(posedge clk_sys) disable iff (rst) (tx_st_q == serial_pkg::TX_START && tx_tick) |=> !txd_q;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // [R21]
  property p_oe_hold;
    @(posedge clk_sys) disable iff (rst) (!ctrl_q.transmit_enable && txbuf_full_q) |=> serial_out_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin released with pending data"); // [R15]
  property p_load;
    @(posedge clk_sys) disable iff (rst) (tx_load && !data_wr) |=> tx_st_q == serial_pkg::TX_START && !txbuf_full_q;
  endproperty
  a_load: assert property (p_load) else $error("shifter load failed"); // [R3]
  property p_parity_out;
    @(posedge clk_sys) disable iff (rst) (tx_st_q == serial_pkg::TX_PAR && tx_tick) |=> txd_q == tx_par_q;
  endproperty
  a_parity_out: assert property (p_parity_out) else $error("parity bit not driven"); // [R14]
  property p_flush;
    @(posedge clk_sys) disable iff (rst) !ctrl_q.receive_enable |=> rx_count_q == 2'h0;
  endproperty
  a_flush: assert property (p_flush) else $error("receive buffer not flushed"); // [R23]
  property p_push;
    @(posedge clk_sys) disable iff (rst) (rx_push && rx_count_q == 2'h0 && !rx_pop) |=> rx_count_q == 2'h1;
  endproperty
  a_push: assert property (p_push) else $error("frame not buffered"); // [R19]
  property p_bresp;
    @(posedge clk_sys) disable iff (rst) wr_fire |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");
  c_frame_sent: cover property (@(posedge clk_sys) disable iff (rst) tx_done);
  c_frame_recv: cover property (@(posedge clk_sys) disable iff (rst) rx_push);
  c_overrun: cover property (@(posedge clk_sys) disable iff (rst) rx_push && rx_count_q == 2'h2);
endmodule : serial_tx_rx_datapath

// ==== hdl/serial_cfg.svh ====
// Functional notes
// R1 - transmit enable hands serial out pin to transmitter
// R2 - synchronous mode transmits on external transfer clock
// R3 - data write fills buffer; shifter loads when free
// R4 - shifter sends whole frame at baud or xck
// R5 - transmit ignores bits above character width
// R6 - software sets ninth bit before low byte
// R7 - data empty flag mirrors transmit buffer empty
// R8 - software writes zero to data empty flag
// R9 - data empty irq held while flag set
// R10 - data write clears empty flag
// R11 - transmit complete when shifter and buffer empty
// R12 - complete flag clears on irq ack or one
// R13 - complete irq raised while flag set
// R14 - parity enable inserts parity after data bits
// R15 - transmit disable waits for pending data drained
// R16 - receive enable claims pin; sync uses xck
// R17 - receiver starts on valid start, samples bits
// R18 - receiver ignores second stop bit
// R19 - first stop bit moves frame into buffer
// R20 - unused upper receive bits read as zero
// R21 - frame start, lsb first data, parity, stops
// R22 - even parity is xor, odd inverted
// R23 - receive complete while buffer holds data; flush
// R24 - character size sets width both directions
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH
`define SER_ADDR_CTRL 8'h00
`define SER_ADDR_STAT 8'h04
`define SER_ADDR_BAUD 8'h08
`define SER_ADDR_DATA 8'h0C
`define SER_CTRL_TX_ON 0
`define SER_CTRL_RXEN 1
`define SER_CTRL_UDRIE 2
`define SER_CTRL_TXCIE 3
`define SER_CTRL_SYNC 4
`define SER_CTRL_U2X 5
`define SER_CTRL_PEN 6
`define SER_CTRL_PODD 7
`define SER_CTRL_STOP2 8
`define SER_CTRL_CSZ_LO 9
`define SER_CTRL_NINTH 12
`define SER_CTRL_GIE 13
`define SER_STAT_UDRE 0
`define SER_STAT_TXC 1
`define SER_STAT_RXC 2
`define SER_STAT_FE 3
`define SER_STAT_PE 4
`define SER_STAT_RXB8 5
`define SER_STAT_DOR 6
`define SER_CSZ_NINE 3'h7
`define SER_BAUD_RESET 12'h000
`endif

// ==== hdl/serial_pkg.sv ====
package serial_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_PAR = 3'h2, TX_STOP = 3'h6
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6
  } rx_state_t;
  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic parity_err;
  } rx_entry_t;
  typedef struct packed {
    logic transmit_enable;
    logic receive_enable;
    logic data_empty_irq_enable;
    logic transmit_complete_irq_enable;
    logic sync_mode;
    logic double_speed;
    logic parity_enable;
    logic parity_odd_select;
    logic stop_bits_select;
    logic [2:0] character_size;
    logic transmit_ninth_bit;
    logic global_irq_enable;
  } ctrl_t;
endpackage : serial_pkg

// ==== tb/serial_partner.sv ====
`timescale 1ns/100ps
module serial_partner #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out
);
  // idle line is pulled high
  initial line_out = 1'b1;

  // only one stop bit is sent, so a receiver set for two must not wait for the second
  task automatic send_frame(input logic [8:0] d, input int nb, input logic pen, input logic odd);
    logic p;
    p = odd;
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      p = p ^ d[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    if (pen) begin
      line_out <= p;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_sys);
  endtask : send_frame

  // samples mid-bit; returns at the middle of the first stop bit
  task automatic recv_frame(input int nb, input logic pen, output logic [8:0] d, output logic p, output logic s);
    d = 9'h000;
    p = 1'b0;
    while (line_in !== 1'b0) @(posedge clk_sys);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      d[i] = line_in;
    end
    if (pen) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      p = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    s = line_in;
  endtask : recv_frame
endmodule : serial_partner

// ==== tb/serial_tx_rx_datapath_tb.sv ====
`timescale 1ns/100ps
`include "serial_cfg.svh"
module serial_tx_rx_datapath_tb;
  localparam int BIT_CLKS = 16;
  localparam int LIMIT = 30000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic serial_in_pin, serial_out_pin, serial_out_oe, serial_in_claimed, irq_data_empty, irq_tx_complete;
  logic xck_in = 1'b0;
  logic xck_run = 1'b0;
  logic irq_ack_tx_complete = 1'b0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int nb;
  logic [31:0] rd, c;
  logic [8:0] d, got, got2, mask;
  logic gp, gs, pen, odd, st2;
  logic [2:0] csz;
  // {char size, parity enable, odd, two stops}
  logic [5:0] fmt [5] = '{6'b000_0_0_0, 6'b001_1_0_0, 6'b010_1_1_1, 6'b011_0_0_1, 6'b111_1_0_0};
  logic [8:0] f_dat [5] = '{9'h1F5, 9'h0EA, 9'h1D3, 9'h0A6, 9'h15C};

  serial_tx_rx_datapath u_dut (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .xck_in(xck_in), .serial_in_claimed(serial_in_claimed), .irq_ack_tx_complete(irq_ack_tx_complete),
    .irq_data_empty(irq_data_empty), .irq_tx_complete(irq_tx_complete)
  );
  serial_partner #(.BIT_CLKS(BIT_CLKS)) u_partner (
    .clk_sys(clk_sys), .line_in(serial_out_pin), .line_out(serial_in_pin)
  );

  always #2 clk_sys = ~clk_sys;

  // external transfer clock, 16 system clocks a bit, only while a sync frame is due
  always @(posedge clk_sys) if (xck_run && cyc % 8 == 0) xck_in <= !xck_in;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_word(input logic [31:0] got_v, input logic [31:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("BAD %0t word %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk_word

  task automatic chk_pin(input logic got_v, input logic exp_v);
    compares++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("BAD %0t bit %b expected %b", $time, got_v, exp_v);
    end
  endtask : chk_pin

  // response ready is raised only once address and data are both taken, so no signal toggles twice in one step
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] dat);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk_sys);
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    axi_rd(`SER_ADDR_STAT, rd, rr);
    while (rd[b] !== v && n < 300) begin
      axi_rd(`SER_ADDR_STAT, rd, rr);
      n++;
    end
    chk_pin(rd[b], v);
  endtask : wait_stat

  function automatic logic [31:0] mk_ctrl(input logic [2:0] cs, input logic pe, input logic od, input logic s2);
    logic [31:0] w;
    w = 32'h0;
    w[`SER_CTRL_TX_ON] = 1'b1;
    w[`SER_CTRL_RXEN] = 1'b1;
    w[`SER_CTRL_PEN] = pe;
    w[`SER_CTRL_PODD] = od;
    w[`SER_CTRL_STOP2] = s2;
    w[`SER_CTRL_CSZ_LO +: 3] = cs;
    return w;
  endfunction : mk_ctrl

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk_pin(serial_out_oe, 1'b0);
    chk_pin(serial_out_pin, 1'b1);
    axi_rd(`SER_ADDR_STAT, rd, rr);
    chk_word(rd & 32'h7, 32'h1);
    axi_rd(32'h10, rd, rr);
    chk_word({30'h0, rr}, 32'h2);
    for (int k = 0; k < 5; k++) begin
      axi_wr(`SER_ADDR_BAUD, k % 2);
      {csz, pen, odd, st2} = fmt[k];
      nb = (csz == `SER_CSZ_NINE) ? 9 : int'(csz) + 5;
      mask = (9'h1 << nb) - 9'h1;
      d = f_dat[k];
      c = mk_ctrl(csz, pen, odd, st2);
      c[`SER_CTRL_NINTH] = d[8];
      c[`SER_CTRL_U2X] = k % 2 == 1;
      axi_wr(`SER_ADDR_CTRL, c);
      @(posedge clk_sys);
      chk_pin(serial_out_oe, 1'b1);
      fork
        axi_wr(`SER_ADDR_DATA, {24'hA5A5A5, d[7:0]});
        u_partner.recv_frame(nb, pen, got, gp, gs);
      join
      chk_word({23'h0, got}, {23'h0, d & mask});
      if (pen) begin
        chk_pin(gp, (^(d & mask)) ^ odd);
      end
      chk_pin(gs, 1'b1);
      wait_stat(`SER_STAT_TXC, 1'b1);
      chk_pin(rd[`SER_STAT_UDRE], 1'b1);
      u_partner.send_frame(d, nb, pen, odd);
      wait_stat(`SER_STAT_RXC, 1'b1);
      chk_word({29'h0, rd[`SER_STAT_PE], rd[`SER_STAT_FE], rd[`SER_STAT_RXB8]}, {31'h0, d[8] & mask[8]});
      axi_rd(`SER_ADDR_DATA, rd, rr);
      chk_word({rd[31:9], rd[7:0]}, {23'h0, d[7:0] & mask[7:0]});
      axi_wr(`SER_ADDR_STAT, 32'h2);
      axi_rd(`SER_ADDR_STAT, rd, rr);
      chk_pin(rd[`SER_STAT_TXC], 1'b0);
    end
    c = mk_ctrl(3'h3, 1'b0, 1'b0, 1'b0);
    c[`SER_CTRL_UDRIE] = 1'b1;
    c[`SER_CTRL_TXCIE] = 1'b1;
    axi_wr(`SER_ADDR_CTRL, c);
    chk_pin(irq_data_empty, 1'b0);
    c[`SER_CTRL_GIE] = 1'b1;
    axi_wr(`SER_ADDR_CTRL, c);
    chk_pin(irq_data_empty, 1'b1);
    chk_pin(irq_tx_complete, 1'b0);
    fork
      begin
        axi_wr(`SER_ADDR_DATA, 32'h3C);
        axi_wr(`SER_ADDR_DATA, 32'hC3);
        axi_rd(`SER_ADDR_STAT, rd, rr);
        chk_pin(rd[`SER_STAT_UDRE], 1'b0);
        chk_pin(irq_data_empty, 1'b0);
        c[`SER_CTRL_TX_ON] = 1'b0;
        axi_wr(`SER_ADDR_CTRL, c);
        chk_pin(serial_out_oe, 1'b1);
      end
      begin
        u_partner.recv_frame(8, 1'b0, got, gp, gs);
        u_partner.recv_frame(8, 1'b0, got2, gp, gs);
      end
    join
    chk_word({14'h0, got, got2}, {14'h0, 9'h03C, 9'h0C3});
    wait_stat(`SER_STAT_TXC, 1'b1);
    chk_pin(irq_tx_complete, 1'b1);
    chk_pin(serial_out_oe, 1'b0);
    chk_pin(serial_out_pin, 1'b1);
    irq_ack_tx_complete <= 1'b1;
    @(posedge clk_sys);
    irq_ack_tx_complete <= 1'b0;
    @(posedge clk_sys);
    chk_pin(irq_tx_complete, 1'b0);
    chk_pin(serial_in_claimed, 1'b1);
    u_partner.send_frame(9'h05A, 8, 1'b0, 1'b0);
    u_partner.send_frame(9'h0A5, 8, 1'b0, 1'b0);
    wait_stat(`SER_STAT_RXC, 1'b1);
    axi_rd(`SER_ADDR_DATA, rd, rr);
    chk_word(rd, 32'h5A);
    wait_stat(`SER_STAT_RXC, 1'b1);
    c[`SER_CTRL_RXEN] = 1'b0;
    axi_wr(`SER_ADDR_CTRL, c);
    chk_pin(serial_in_claimed, 1'b0);
    axi_rd(`SER_ADDR_STAT, rd, rr);
    chk_pin(rd[`SER_STAT_RXC], 1'b0);
    c = mk_ctrl(3'h3, 1'b0, 1'b0, 1'b0);
    c[`SER_CTRL_SYNC] = 1'b1;
    axi_wr(`SER_ADDR_CTRL, c);
    xck_run <= 1'b1;
    fork
      axi_wr(`SER_ADDR_DATA, 32'h96);
      u_partner.recv_frame(8, 1'b0, got, gp, gs);
    join
    chk_word({23'h0, got}, 32'h96);
    chk_pin(gs, 1'b1);
    wait_stat(`SER_STAT_TXC, 1'b1);
    xck_run <= 1'b0;
    print_verdict();
  end
endmodule : serial_tx_rx_datapath_tb
